// ==== rtl/dcf_pkg.sv ====
/*
 * Shared constants and types for the dual-port FIFO with mode and status flag logic.
 * Assumes a single clock domain and a classic Wishbone slave with 32-bit data.
 */
package dcf_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_STATUS      = 8'h00;
  localparam logic [7:0] REG_EMPTY_OFS   = 8'h04;
  localparam logic [7:0] REG_FULL_OFS    = 8'h08;

  // ****************************************************************
  // Status register field positions
  // ****************************************************************
  localparam int STAT_COUNT_LSB  = 0;
  localparam int STAT_COUNT_W    = 24;
  localparam int STAT_FLAGS_LSB  = 24;
  localparam int STAT_LOADSEL    = 30;
  localparam int STAT_MODE       = 31;

  // ****************************************************************
  // Register stages of the flag paths
  // ****************************************************************
  localparam int EMPTY_STAGES    = 2;
  localparam int FULL_STAGES     = 2;
  localparam int VALID_STAGES    = 3;
  localparam int SPACE_STAGES    = 2;

  // ****************************************************************
  // Default offsets chosen by load select and the two offset selects
  // ****************************************************************
  localparam int unsigned OFS_LLL = 127;
  localparam int unsigned OFS_LLH = 16383;
  localparam int unsigned OFS_LHL = 8191;
  localparam int unsigned OFS_LHH = 4095;
  localparam int unsigned OFS_HLL = 1023;
  localparam int unsigned OFS_HLH = 2047;
  localparam int unsigned OFS_HHL = 511;
  localparam int unsigned OFS_HHH = 255;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [0:0] {
    DCF_MODE_STANDARD     = 1'b0,
    DCF_MODE_FALL_THROUGH = 1'b1
  } dcf_mode_type;

  typedef struct packed {
    logic empty_indicator_n;
    logic almost_empty_indicator_n;
    logic half_full_indicator_n;
    logic almost_full_indicator_n;
    logic full_indicator_n;
    logic output_valid_n;
  } dcf_flags_type;

  // Flag levels right after reset: empty, below every threshold, space free.
  localparam dcf_flags_type FLAGS_RESET = '{
    empty_indicator_n:        1'b0,
    almost_empty_indicator_n: 1'b0,
    half_full_indicator_n:    1'b1,
    almost_full_indicator_n:  1'b1,
    full_indicator_n:         1'b1,
    output_valid_n:           1'b1
  };

endpackage : dcf_pkg

// ==== rtl/dcf_flag_pipe.sv ====
/*
 * A chain of register stages that delays one flag level by a fixed number of clocks.
 * Assumes the input comes from logic on the same clock; reset loads a fixed level.
 */
`timescale 1ns/1ps
module dcf_flag_pipe #(
  parameter int   STAGES    = 2,
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic flag_in,
  output wire logic flag_out
);

  logic [STAGES-1:0] stage;

  always_ff @(posedge clk) begin
    if (srst) begin
      stage <= {STAGES{RESET_VAL}};
    end else begin
      stage <= {stage[STAGES-2:0], flag_in};
    end
  end

  assign flag_out = stage[STAGES-1];

endmodule : dcf_flag_pipe

// ==== rtl/dcf_fifo.sv ====
/*
 * Deep FIFO with standard and fall-through timing modes, status flags and a Wishbone
 * register port for the empty and full offsets.
 * Assumes writer and reader logic run on clk; straps are pins and are synchronised.
 */
// The address map and the Wishbone slave port were decided locally.
// What this block does
// - Strap sampled low during reset selects standard timing mode.
// - Strap sampled high during reset selects fall-through mode.
// - In fall-through mode the first word appears after three clocks unrequested.
// - Fall-through mode shows output-valid and input-space indicators.
// - Each clock edge with write request low stores one input word unless D words are held.
// - Empty indicator goes high once the first word is written.
// - Almost-empty indicator goes high when occupancy reaches n plus one.
// - Half-full indicator goes low when occupancy reaches D/2 plus one.
// - Almost-full indicator goes low when occupancy reaches D minus m.
// - Depth D is a parameter matching the organisation and bus widths.
// - At D words full indicator goes low and writes are ignored.
// - Full indicator returns high after the first read from full.
// - Almost-empty indicator goes low when n words remain.
// - Reading the last word drives empty low and blocks reads.
// - Reads while empty leave pointer and outputs unchanged.
// - Empty and full indicators pass through three register stages: two pipe stages and the flag register.
// - Reset loads default offsets chosen by load and offset selects.
`timescale 1ns/1ps
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int DATA_W = 18,
  parameter int DEPTH  = 131072
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 mode_select_serial_in,
  input  wire logic                 load_select_n,
  input  wire logic                 offset_select_0,
  input  wire logic                 offset_select_1,
  input  wire logic                 wr_req_n,
  input  wire logic [DATA_W-1:0]    data_in_bus,
  input  wire logic                 rd_req_n,
  output wire logic [DATA_W-1:0]    data_out_bus,
  output wire logic                 empty_indicator_n,
  output wire logic                 almost_empty_indicator_n,
  output wire logic                 half_full_indicator_n,
  output wire logic                 almost_full_indicator_n,
  output wire logic                 full_indicator_n,
  output wire logic                 output_valid_n,
  output wire logic                 input_space_indicator_n,
  output wire dcf_pkg::dcf_mode_type fall_through_mode,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output wire logic [31:0]          wb_dat_o,
  output wire logic                 wb_ack_o
);

  import dcf_pkg::*;

  localparam int ADDR_W = $clog2(DEPTH);
  localparam int CNT_W  = ADDR_W + 1;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] HALF_C  = CNT_W'(DEPTH / 2 + 1);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [ADDR_W-1:0] default_offset(input logic lsel_n,
                                                       input logic s0,
                                                       input logic s1);
    int unsigned v;
    v = OFS_LLL;
    unique case ({lsel_n, s0, s1})
      3'b000: v = OFS_LLL;
      3'b001: v = OFS_LLH;
      3'b010: v = OFS_LHL;
      3'b011: v = OFS_LHH;
      3'b100: v = OFS_HLL;
      3'b101: v = OFS_HLH;
      3'b110: v = OFS_HHL;
      3'b111: v = OFS_HHH;
    endcase
    return ADDR_W'(v);
  endfunction : default_offset

  function automatic logic [ADDR_W-1:0] merge_bytes(input logic [ADDR_W-1:0] old,
                                                    input logic [31:0]       wdat,
                                                    input logic [3:0]        sel);
    logic [31:0] w;
    w = 32'(old);
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        w[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return w[ADDR_W-1:0];
  endfunction : merge_bytes

  // ****************************************************************
  // Strap synchronisers and capture at reset
  // ****************************************************************
  logic [3:0] strap_meta;
  logic [3:0] strap_sync;
  dcf_mode_type mode;
  logic         load_mode_n;
  logic [ADDR_W-1:0] empty_ofs;
  logic [ADDR_W-1:0] full_ofs;

  always_ff @(posedge clk) begin
    strap_meta <= {mode_select_serial_in, load_select_n, offset_select_0, offset_select_1};
    strap_sync <= strap_meta;
  end

  // The other party holds the straps through reset, so the last sample before
  // release is the one kept.
  always_ff @(posedge clk) begin
    if (srst) begin
      mode        <= dcf_mode_type'(strap_sync[3]);
      load_mode_n <= strap_sync[2];
    end
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  logic        ack;
  logic [31:0] rdat;
  wire         bus_req   = wb_cyc_i & wb_stb_i & ~ack;
  wire         bus_wr    = bus_req & wb_we_i;
  wire         hit_stat  = (wb_adr_i == REG_STATUS);
  wire         hit_empty = (wb_adr_i == REG_EMPTY_OFS);
  wire         hit_full  = (wb_adr_i == REG_FULL_OFS);

  always_ff @(posedge clk) begin
    if (srst) begin
      empty_ofs <= default_offset(strap_sync[2], strap_sync[1], strap_sync[0]);
      full_ofs  <= default_offset(strap_sync[2], strap_sync[1], strap_sync[0]);
    end else begin
      if (bus_wr && hit_empty) begin
        empty_ofs <= merge_bytes(empty_ofs, wb_dat_i, wb_sel_i);
      end
      if (bus_wr && hit_full) begin
        full_ofs <= merge_bytes(full_ofs, wb_dat_i, wb_sel_i);
      end
    end
  end

  // ****************************************************************
  // Storage, pointers and occupancy
  // ****************************************************************
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wr_ptr;
  logic [ADDR_W-1:0] rd_ptr;
  logic [CNT_W-1:0]  count;
  logic [DATA_W-1:0] dout;
  dcf_flags_type     flags;

  wire is_ft    = (mode == DCF_MODE_FALL_THROUGH);
  wire count_nz = (count != '0);
  // Writes past D words are dropped; the full flag lags by two clocks.
  wire wr_ok    = ~wr_req_n & (count != DEPTH_C);
  // A read needs stored data and a flag that already told the reader so.
  wire rd_ok    = ~rd_req_n & count_nz &
                  (is_ft ? ~flags.output_valid_n : flags.empty_indicator_n);

  wire [CNT_W-1:0]  next_count = wr_ok && !rd_ok ? count + CNT_W'(1) :
                                 rd_ok && !wr_ok ? count - CNT_W'(1) : count;
  wire [ADDR_W-1:0] next_rd_ptr = rd_ok ? rd_ptr + ADDR_W'(1) : rd_ptr;

  always_ff @(posedge clk) begin
    if (wr_ok) begin
      mem[wr_ptr] <= data_in_bus;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= wr_ok ? wr_ptr + ADDR_W'(1) : wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // ****************************************************************
  // Data output
  // ****************************************************************
  // Fall-through mode keeps the head word on the outputs every clock, so a word
  // written into an empty FIFO is there before the valid flag drops.
  wire next_dout_ft  = next_count != '0;
  wire load_dout     = is_ft ? next_dout_ft : rd_ok;

  always_ff @(posedge clk) begin
    if (srst) begin
      dout <= '0;
    end else if (load_dout) begin
      dout <= is_ft ? mem[next_rd_ptr] : mem[rd_ptr];
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  wire empty_raw_n = next_count != '0;
  wire full_raw_n  = next_count != DEPTH_C;
  wire empty_q_n;
  wire full_q_n;
  wire valid_q_n;
  wire space_q_n;

  dcf_flag_pipe #(.STAGES(EMPTY_STAGES), .RESET_VAL(1'b0)) u_empty_pipe (
    .clk      (clk),
    .srst     (srst),
    .flag_in  (empty_raw_n),
    .flag_out (empty_q_n)
  );

  dcf_flag_pipe #(.STAGES(FULL_STAGES), .RESET_VAL(1'b1)) u_full_pipe (
    .clk      (clk),
    .srst     (srst),
    .flag_in  (full_raw_n),
    .flag_out (full_q_n)
  );

  dcf_flag_pipe #(.STAGES(VALID_STAGES), .RESET_VAL(1'b1)) u_valid_pipe (
    .clk      (clk),
    .srst     (srst),
    .flag_in  (~empty_raw_n),
    .flag_out (valid_q_n)
  );

  dcf_flag_pipe #(.STAGES(SPACE_STAGES), .RESET_VAL(1'b0)) u_space_pipe (
    .clk      (clk),
    .srst     (srst),
    .flag_in  (~full_raw_n),
    .flag_out (space_q_n)
  );

  logic space_n;
  wire [CNT_W-1:0] ae_limit = CNT_W'(empty_ofs) + CNT_W'(1);
  wire [CNT_W-1:0] af_limit = DEPTH_C - CNT_W'(full_ofs);

  dcf_flags_type next_flags;
  always_comb begin
    next_flags                          = flags;
    next_flags.empty_indicator_n        = is_ft ? 1'b1 : empty_q_n;
    next_flags.full_indicator_n         = is_ft ? 1'b1 : full_q_n;
    next_flags.output_valid_n           = is_ft ? valid_q_n : 1'b1;
    next_flags.almost_empty_indicator_n = next_count >= ae_limit;
    next_flags.half_full_indicator_n    = ~(next_count >= HALF_C);
    next_flags.almost_full_indicator_n  = ~(next_count >= af_limit);
  end

  // The pipes already carry two or three stages; this last register picks the mode-dependent
  // pin, so piped pins see one more clock; the threshold flags come straight from next_count.
  always_ff @(posedge clk) begin
    if (srst) begin
      flags   <= FLAGS_RESET;
      space_n <= 1'b0;
    end else begin
      flags   <= next_flags;
      space_n <= is_ft ? space_q_n : 1'b1;
    end
  end

  // ****************************************************************
  // Register read data
  // ****************************************************************
  wire [31:0] stat_word = {mode, load_mode_n,
                           flags.output_valid_n, flags.full_indicator_n,
                           flags.almost_full_indicator_n, flags.half_full_indicator_n,
                           flags.almost_empty_indicator_n, flags.empty_indicator_n,
                           STAT_COUNT_W'(count)};
  wire [31:0] read_mux = hit_stat  ? stat_word :
                         hit_empty ? 32'(empty_ofs) :
                         hit_full  ? 32'(full_ofs) : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack  <= 1'b0;
      rdat <= 32'h0000_0000;
    end else begin
      ack  <= bus_req;
      rdat <= bus_req ? read_mux : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign data_out_bus             = dout;
  assign empty_indicator_n        = flags.empty_indicator_n;
  assign almost_empty_indicator_n = flags.almost_empty_indicator_n;
  assign half_full_indicator_n    = flags.half_full_indicator_n;
  assign almost_full_indicator_n  = flags.almost_full_indicator_n;
  assign full_indicator_n         = flags.full_indicator_n;
  assign output_valid_n           = flags.output_valid_n;
  assign input_space_indicator_n  = space_n;
  assign fall_through_mode        = mode;
  assign wb_dat_o                 = rdat;
  assign wb_ack_o                 = ack;

endmodule : dcf_fifo

// ==== tb/dcf_fifo_chk.sv ====
/* Assertion checker for dcf_fifo, bound into every instance of it.
   Sees only the top ports; assumes the straps stay stable around each reset. */
`timescale 1ns/1ps
module dcf_fifo_chk
  import dcf_pkg::*;
#(
  parameter int DATA_W = 18,
  parameter int DEPTH  = 131072
) (
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  mode_select_serial_in,
  input wire logic                  wr_req_n,
  input wire logic                  rd_req_n,
  input wire logic [DATA_W-1:0]     data_out_bus,
  input wire logic                  empty_indicator_n,
  input wire logic                  half_full_indicator_n,
  input wire logic                  full_indicator_n,
  input wire logic                  output_valid_n,
  input wire dcf_pkg::dcf_mode_type fall_through_mode,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o
);
  // ****************************************************************
  // Occupancy model
  // ****************************************************************
  localparam int OW = $clog2(DEPTH) + 1;
  logic [OW-1:0] occ;
  wire logic std_mode = (fall_through_mode == DCF_MODE_STANDARD);
  wire logic wr_take = !wr_req_n && (occ < OW'(DEPTH));
  wire logic rd_take = !rd_req_n && (occ != '0) && (std_mode ? empty_indicator_n : !output_valid_n);
  wire logic [OW-1:0] next_occ = occ + OW'(wr_take) - OW'(rd_take);

  always_ff @(posedge clk) begin
    occ <= srst ? '0 : next_occ;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_mode_capture: assert property (
    $fell(srst) |-> fall_through_mode == dcf_mode_type'(mode_select_serial_in))
    else $error("mode differs from strap at reset release");
  a_first_write: assert property (
    (std_mode && !wr_req_n) ##1 rd_req_n [*4] |-> empty_indicator_n)
    else $error("empty flag stayed low after a write");
  a_empty_block: assert property (
    std_mode && !empty_indicator_n |=> $stable(data_out_bus))
    else $error("read data moved while empty");
  a_last_read: assert property (
    (std_mode && occ == OW'(1) && rd_take && wr_req_n) ##1 wr_req_n [*4] |-> !empty_indicator_n)
    else $error("empty flag not low after last read");
  a_full_hold: assert property (
    (std_mode && occ == OW'(DEPTH)) [*4] |-> !full_indicator_n)
    else $error("full flag high while full");
  a_full_release: assert property (
    (std_mode && !full_indicator_n && !rd_req_n) ##1 wr_req_n [*4] |-> full_indicator_n)
    else $error("full flag stuck low after read");
  a_half_level: assert property (
    std_mode |-> half_full_indicator_n == (occ <= OW'(DEPTH / 2)))
    else $error("half full flag wrong for occupancy");
  a_valid_std: assert property (
    std_mode |-> output_valid_n)
    else $error("output valid shown in standard mode");
  a_fall_first: assert property (
    (!std_mode && occ == '0 && !wr_req_n) |-> ##[3:5] !output_valid_n)
    else $error("first word did not fall through");
  a_wb_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
endmodule : dcf_fifo_chk

bind dcf_fifo dcf_fifo_chk #(.DATA_W(DATA_W), .DEPTH(DEPTH)) chk_u (
  .clk(clk), .srst(srst), .mode_select_serial_in(mode_select_serial_in),
  .wr_req_n(wr_req_n), .rd_req_n(rd_req_n), .data_out_bus(data_out_bus),
  .empty_indicator_n(empty_indicator_n), .half_full_indicator_n(half_full_indicator_n),
  .full_indicator_n(full_indicator_n), .output_valid_n(output_valid_n),
  .fall_through_mode(fall_through_mode), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o));

// ==== tb/dcf_partner.sv ====
/* Writer and reader logic facing the FIFO data ports.
   Its tasks are entered right after a rising edge of the shared clock. */
`timescale 1ns/1ps
module dcf_partner #(
  parameter int DATA_W = 18
) (
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] data_out_bus,
  output logic                   wr_req_n,
  output logic [DATA_W-1:0]      data_in_bus,
  output logic                   rd_req_n
);
  logic [DATA_W-1:0] sent_q[$];
  logic [DATA_W-1:0] got_q[$];

  initial begin
    wr_req_n    = 1'b1;
    rd_req_n    = 1'b1;
    data_in_bus = '0;
  end

  // Keep is low when the words are left out of the data check, such as words the FIFO drops.
  task automatic push(input int n, input bit gaps, input bit keep);
    logic [DATA_W-1:0] w;
    for (int i = 0; i < n; i++) begin
      w = DATA_W'($urandom);
      wr_req_n    <= 1'b0;
      data_in_bus <= w;
      @(posedge clk);
      if (keep) sent_q.push_back(w);
      if (gaps && $urandom_range(1, 0) == 1) begin
        wr_req_n    <= 1'b1;
        data_in_bus <= ~w;
        @(posedge clk);
      end
    end
    wr_req_n    <= 1'b1;
    // Idle lines toggle so a stale word can never pass for a fresh one.
    data_in_bus <= ~data_in_bus;
  endtask : push

  task automatic pull(input int n);
    rd_req_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (i == n - 1) rd_req_n <= 1'b1;
      @(negedge clk);
      got_q.push_back(data_out_bus);
    end
    @(posedge clk);
  endtask : pull
endmodule : dcf_partner

// ==== tb/test_dual_clock_fifo_flag_logic.sv ====
/* Self-checking bench for dcf_fifo with a small depth and bus-programmed offsets.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD %s expected %0h seen %0h", what, exp, got); end end
module test_dual_clock_fifo_flag_logic;
  import dcf_pkg::*;
  localparam int DW = 18;
  localparam int DEPTH = 16;
  localparam int N_OFS = 3;
  localparam int M_OFS = 4;
  localparam int LIMIT = 6000;
  logic clk = 1'b0, srst = 1'b1, mode_select_serial_in = 1'b0, load_select_n = 1'b0;
  logic offset_select_0 = 1'b0, offset_select_1 = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, rdat;
  wire logic wr_req_n, rd_req_n, wb_ack_o, empty_indicator_n, almost_empty_indicator_n;
  wire logic half_full_indicator_n, almost_full_indicator_n, full_indicator_n;
  wire logic output_valid_n, input_space_indicator_n;
  wire logic [DW-1:0] data_in_bus, data_out_bus;
  wire logic [31:0] wb_dat_o;
  wire dcf_mode_type fall_through_mode;
  wire dcf_flags_type seen = {empty_indicator_n, almost_empty_indicator_n,
    half_full_indicator_n, almost_full_indicator_n, full_indicator_n, output_valid_n};
  int bad_count = 0, compares = 0, cycles = 0, occ;

  always #50 clk = ~clk;

  dcf_fifo #(.DATA_W(DW), .DEPTH(DEPTH)) dut_u (.clk(clk), .srst(srst),
    .mode_select_serial_in(mode_select_serial_in), .load_select_n(load_select_n),
    .offset_select_0(offset_select_0), .offset_select_1(offset_select_1),
    .wr_req_n(wr_req_n), .data_in_bus(data_in_bus), .rd_req_n(rd_req_n),
    .data_out_bus(data_out_bus), .empty_indicator_n(empty_indicator_n),
    .almost_empty_indicator_n(almost_empty_indicator_n),
    .half_full_indicator_n(half_full_indicator_n),
    .almost_full_indicator_n(almost_full_indicator_n), .full_indicator_n(full_indicator_n),
    .output_valid_n(output_valid_n), .input_space_indicator_n(input_space_indicator_n),
    .fall_through_mode(fall_through_mode), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  dcf_partner #(.DATA_W(DW)) partner_u (.clk(clk), .data_out_bus(data_out_bus),
    .wr_req_n(wr_req_n), .data_in_bus(data_in_bus), .rd_req_n(rd_req_n));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic conclude();
    $display("counts: %0d compares, %0d bad", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic do_reset(input logic mode, input logic lsel);
    srst <= 1'b1;
    mode_select_serial_in <= mode;
    load_select_n <= lsel;
    offset_select_0 <= 1'($urandom_range(1, 0));
    offset_select_1 <= 1'($urandom_range(1, 0));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
  endtask : do_reset

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int t;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    t = 0;
    // Acknowledge and read data are taken at the edge that samples ack high.
    do begin
      @(posedge clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    `CHK("ack", 1'b1, wb_ack_o)
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb_xfer

  function automatic logic [31:0] def_ofs(input logic [2:0] s);
    int unsigned t [8];
    t = '{OFS_LLL, OFS_LLH, OFS_LHL, OFS_LHH, OFS_HLL, OFS_HLH, OFS_HHL, OFS_HHH};
    return 32'(t[s] % DEPTH);
  endfunction : def_ofs

  function automatic dcf_flags_type exp_flags(input int n);
    exp_flags = '{empty_indicator_n: n != 0, almost_empty_indicator_n: n > N_OFS,
      half_full_indicator_n: n <= DEPTH / 2, almost_full_indicator_n: n < DEPTH - M_OFS,
      full_indicator_n: n != DEPTH, output_valid_n: 1'b1};
  endfunction : exp_flags

  task automatic flags_at(input int n);
    repeat (5) @(posedge clk);
    @(negedge clk);
    `CHK("flags", exp_flags(n), seen)
    @(posedge clk);
  endtask : flags_at

  task automatic check_data();
    logic [DW-1:0] e, g;
    `CHK("words", partner_u.sent_q.size(), partner_u.got_q.size())
    while (partner_u.got_q.size() > 0) begin
      g = partner_u.got_q.pop_front();
      e = partner_u.sent_q.size() > 0 ? partner_u.sent_q.pop_front() : ~g;
      `CHK("word", e, g)
    end
    partner_u.sent_q.delete();
  endtask : check_data

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    occ = $urandom(57858);
    do_reset(1'b0, 1'b0);
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    `CHK("mode bit", 1'b0, rdat[STAT_MODE])
    `CHK("load bit", 1'b0, rdat[STAT_LOADSEL])
    wb_xfer(1'b0, REG_EMPTY_OFS, 32'h0);
    `CHK("default n", def_ofs({load_select_n, offset_select_0, offset_select_1}), rdat)
    wb_xfer(1'b1, REG_EMPTY_OFS, 32'(N_OFS));
    wb_xfer(1'b1, REG_FULL_OFS, 32'(M_OFS));
    wb_xfer(1'b0, REG_FULL_OFS, 32'h0);
    `CHK("full offset", 32'(M_OFS), rdat)
    wb_xfer(1'b1, 8'h0C, 32'hFFFFFFFF);
    wb_xfer(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    $display("test registers done");
    partner_u.push(1, 1'b0, 1'b1);
    @(negedge clk);
    `CHK("empty lag", 1'b0, empty_indicator_n)
    `CHK("space std", 1'b1, input_space_indicator_n)
    @(posedge clk);
    flags_at(1);
    partner_u.pull(1);
    flags_at(0);
    partner_u.pull(1);
    partner_u.sent_q.push_back(partner_u.sent_q[0]);
    check_data();
    $display("test first word done");
    for (int k = 1; k <= DEPTH; k++) begin
      partner_u.push(1, 1'b0, 1'b1);
      flags_at(k);
    end
    partner_u.push(2, 1'b0, 1'b0);
    flags_at(DEPTH);
    for (int k = DEPTH - 1; k >= 0; k--) begin
      partner_u.pull(1);
      flags_at(k);
    end
    check_data();
    $display("test fill and drain done");
    for (int r = 0; r < 6; r++) begin
      occ = $urandom_range(DEPTH, 1);
      partner_u.push(occ, 1'b1, 1'b1);
      flags_at(occ);
      partner_u.pull(occ);
      flags_at(0);
    end
    check_data();
    $display("test random bursts done");
    do_reset(1'b1, 1'b1);
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    `CHK("mode bit", 1'b1, rdat[STAT_MODE])
    `CHK("load bit", 1'b1, rdat[STAT_LOADSEL])
    wb_xfer(1'b0, REG_FULL_OFS, 32'h0);
    `CHK("default m", def_ofs({load_select_n, offset_select_0, offset_select_1}), rdat)
    partner_u.push(3, 1'b0, 1'b1);
    occ = 0;
    do begin
      @(negedge clk);
      occ++;
    end while (output_valid_n !== 1'b0 && occ < 10);
    `CHK("first word", partner_u.sent_q[0], data_out_bus)
    @(posedge clk);
    partner_u.pull(1);
    repeat (5) @(posedge clk);
    @(negedge clk);
    `CHK("second word", partner_u.sent_q[1], data_out_bus)
    `CHK("valid", 1'b0, output_valid_n)
    `CHK("space", 1'b0, input_space_indicator_n)
    @(posedge clk);
    partner_u.push(DEPTH - 1, 1'b0, 1'b0);
    repeat (5) @(posedge clk);
    @(negedge clk);
    `CHK("space full", 1'b1, input_space_indicator_n)
    $display("test fall through done");
    conclude();
  end
endmodule : test_dual_clock_fifo_flag_logic
